// file: rtl/csw_params.svh
/*
 Status word constants: APB offset, bit positions, reset value, write mask.
 Assumes inclusion from the status word module and the testbench only.
*/
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH
`define CSW_STATUS_WORD_OFFSET 12'h0d0
`define CSW_BIT_CARRY 7
`define CSW_BIT_HALF_CARRY 6
`define CSW_BIT_USER0 5
`define CSW_BIT_BANK_HIGH 4
`define CSW_BIT_BANK_LOW 3
`define CSW_BIT_WRAP 2
`define CSW_BIT_USER1 1
`define CSW_BIT_PARITY 0
`define CSW_STATUS_RESET 8'h00
`define CSW_WRITE_MASK 8'hfe
`define CSW_BANK_SIZE 8
`define CSW_BCD_LIMIT 9'h064
`endif

// file: rtl/csw_pkg.sv
/*
 Types for the status word block: operation codes and carried records.
 Assumes csw_params.svh for the numeric constants.
*/
package csw_pkg;
	typedef enum logic [3:0] {
		CSW_OP_NONE,
		CSW_OP_ADD,
		CSW_OP_ADDC,
		CSW_OP_SUBTRACT_WITH_BORROW,
		CSW_OP_MUL,
		CSW_OP_DIV,
		CSW_OP_DA,
		CSW_OP_COMPARE_JUMP_NOT_EQUAL,
		CSW_OP_SETC,
		CSW_OP_CLRC,
		CSW_OP_CPLC,
		CSW_OP_MOVC
	} csw_op_t;

	typedef struct packed {
		logic valid;
		csw_op_t op;
		logic [7:0] opnd_a;
		logic [7:0] opnd_b;
		logic bit_in;
		logic wrap_in;
	} csw_exec_t;

	typedef struct packed {
		logic [7:0] word;
		logic [7:0] prdata;
		logic pready;
		logic pslverr;
		logic [4:0] bank_base;
	} csw_state_t;
endpackage

// file: rtl/csw_status_word.sv
/*
 Processor status word: arithmetic flags, user flags, bank select, parity,
 reached over APB. Assumes the execution unit presents one completed
 operation per valid cycle and reports wrap for product/quotient ops itself.
*/
// Chosen here: the APB register port.
// Behaviour
// - add or subtract sets carry on MSB carry-out or borrow-in, else clears.
// - multiply or divide completion always clears carry.
// - decimal adjust sets carry when packed BCD sum exceeds 99.
// - compare-jump sets carry when first unsigned operand is below second.
// - half carry follows carry out of or borrow into low nibble top bit.
// - bit 5 is a user flag; software only, hardware never changes it.
// - bits 4 and 3 are writable bank-select bits.
// - reset clears the whole status word to zero.
// - bank bits choose one of four eight-register banks for R0..R7.
// - add sets wrap when exactly one of bit 6 and bit 7 carries out.
// - parity is read-only, one when accumulator has odd count of ones.
`include "csw_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csw_status_word
	import csw_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// execution unit
	input wire csw_exec_t i_exec,
	input wire logic [7:0] i_accumulator,
	// status outputs
	output logic [7:0] o_status_word,
	output logic [4:0] o_bank_base
);
	initial begin
		if (ADDR_W < 8) begin
			$error("ADDR_W too narrow for status word offset");
		end
		if (ADDR_W > 32) begin
			$error("ADDR_W wider than the bus address");
		end
	end

	csw_state_t st;
	csw_state_t next_st;

	logic [8:0] sum_full;
	logic [4:0] sum_low;
	logic [7:0] sum_c6;
	logic [8:0] dif_full;
	logic [4:0] dif_low;
	logic [7:0] dif_c6;
	logic [8:0] da_val;
	logic parity;
	logic apb_hit;
	logic apb_acc;
	logic cin;

	assign cin = (i_exec.op == CSW_OP_ADD) ? 1'b0 : st.word[`CSW_BIT_CARRY];
	assign sum_full = {1'b0, i_exec.opnd_a} + {1'b0, i_exec.opnd_b} + {8'h00, cin};
	assign sum_low = {1'b0, i_exec.opnd_a[3:0]} + {1'b0, i_exec.opnd_b[3:0]} + {4'h0, cin};
	assign sum_c6 = {1'b0, i_exec.opnd_a[6:0]} + {1'b0, i_exec.opnd_b[6:0]} + {7'h00, cin};
	assign dif_full = {1'b0, i_exec.opnd_a} - {1'b0, i_exec.opnd_b} - {8'h00, cin};
	assign dif_low = {1'b0, i_exec.opnd_a[3:0]} - {1'b0, i_exec.opnd_b[3:0]} - {4'h0, cin};
	assign dif_c6 = {1'b0, i_exec.opnd_a[6:0]} - {1'b0, i_exec.opnd_b[6:0]} - {7'h00, cin};
	assign parity = ^i_accumulator;
	assign apb_hit = (i_paddr == ADDR_W'(`CSW_STATUS_WORD_OFFSET));
	assign apb_acc = i_psel && i_penable && !st.pready;

	// decimal adjust of the accumulator held in opnd_a
	always_comb begin
		da_val = {1'b0, i_exec.opnd_a};
		if (da_val[3:0] > 4'h9 || st.word[`CSW_BIT_HALF_CARRY]) begin
			da_val = da_val + 9'h006;
		end
		if (da_val[8:4] > 5'h09 || st.word[`CSW_BIT_CARRY]) begin
			da_val = da_val + 9'h060;
		end
	end

	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		// software access, taken in the first access cycle, answered next cycle
		if (apb_acc) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !apb_hit;
			next_st.prdata = 8'h00;
			if (apb_hit && i_pwrite && i_pstrb[0]) begin
				next_st.word = i_pwdata[7:0] & `CSW_WRITE_MASK;
			end else if (apb_hit && !i_pwrite) begin
				next_st.prdata = {st.word[7:1], parity};
			end
		end
		// a completing instruction's flag results win over a same-cycle software write; other written bits still land
		if (i_exec.valid) begin
			case (i_exec.op)
				CSW_OP_ADD, CSW_OP_ADDC: begin
					next_st.word[`CSW_BIT_CARRY] = sum_full[8];
					next_st.word[`CSW_BIT_HALF_CARRY] = sum_low[4];
					next_st.word[`CSW_BIT_WRAP] = sum_full[8] ^ sum_c6[7];
				end
				CSW_OP_SUBTRACT_WITH_BORROW: begin
					next_st.word[`CSW_BIT_CARRY] = dif_full[8];
					next_st.word[`CSW_BIT_HALF_CARRY] = dif_low[4];
					next_st.word[`CSW_BIT_WRAP] = dif_full[8] ^ dif_c6[7];
				end
				CSW_OP_MUL, CSW_OP_DIV: begin
					next_st.word[`CSW_BIT_CARRY] = 1'b0;
					next_st.word[`CSW_BIT_WRAP] = i_exec.wrap_in;
				end
				CSW_OP_DA: begin
					// carry only ever sets here, keeping a prior decimal carry
					next_st.word[`CSW_BIT_CARRY] = st.word[`CSW_BIT_CARRY] | da_val[8];
				end
				CSW_OP_COMPARE_JUMP_NOT_EQUAL: begin
					next_st.word[`CSW_BIT_CARRY] = (i_exec.opnd_a < i_exec.opnd_b);
				end
				CSW_OP_SETC: begin
					next_st.word[`CSW_BIT_CARRY] = 1'b1;
				end
				CSW_OP_CLRC: begin
					next_st.word[`CSW_BIT_CARRY] = 1'b0;
				end
				CSW_OP_CPLC: begin
					next_st.word[`CSW_BIT_CARRY] = !st.word[`CSW_BIT_CARRY];
				end
				CSW_OP_MOVC: begin
					next_st.word[`CSW_BIT_CARRY] = i_exec.bit_in;
				end
				default: begin
					// flags hold their previous values
					next_st.word = next_st.word;
				end
			endcase
		end
		next_st.word[`CSW_BIT_PARITY] = parity;
		next_st.bank_base = 5'({next_st.word[`CSW_BIT_BANK_HIGH], next_st.word[`CSW_BIT_BANK_LOW]})
			* 5'(`CSW_BANK_SIZE);
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st.word <= `CSW_STATUS_RESET;
			st.prdata <= 8'h00;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
			st.bank_base <= 5'h00;
		end else begin
			st <= next_st;
		end
	end

	assign o_prdata = {24'h000000, st.prdata};
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_status_word = st.word;
	assign o_bank_base = st.bank_base;

	// named steps shared by the bus-side properties
	sequence s_soft_write;
		i_rst_n && apb_acc && apb_hit && i_pwrite && i_pstrb[0];
	endsequence

	sequence s_bank_land;
		o_status_word[4:3] == $past(i_pwdata[4:3]) ##1 o_bank_base == 5'({o_status_word[4:3], 3'b000});
	endsequence

	// expectations use operand arithmetic, not the datapath nets above
	a_add_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADD
		|=> o_status_word[7] == ($past(i_exec.opnd_a) + 9'($past(i_exec.opnd_b)) > 9'h0ff))
		else $error("add carry wrong");

	a_sub_borrow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_SUBTRACT_WITH_BORROW && !o_status_word[7]
		|=> o_status_word[7] == ($past(i_exec.opnd_a) < $past(i_exec.opnd_b)))
		else $error("subtract borrow wrong");

	a_mul_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && (i_exec.op == CSW_OP_MUL || i_exec.op == CSW_OP_DIV)
		|=> !o_status_word[7])
		else $error("carry not cleared by multiply or divide");

	a_da_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_DA && i_exec.opnd_a > 8'h99
		|=> o_status_word[7])
		else $error("decimal adjust carry missing");

	a_cmp_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_COMPARE_JUMP_NOT_EQUAL
		|=> o_status_word[7] == ($past(i_exec.opnd_a) < $past(i_exec.opnd_b)))
		else $error("compare carry wrong");

	a_half_add: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADD
		|=> o_status_word[6] == (5'($past(i_exec.opnd_a[3:0])) + 5'($past(i_exec.opnd_b[3:0])) > 5'h0f))
		else $error("half carry wrong");

	a_user_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rst_n && !(i_psel && i_penable && i_pwrite) |=> $stable(o_status_word[5]))
		else $error("user flag changed by hardware");

	a_bank_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_soft_write |=> s_bank_land)
		else $error("bank select not written");

	a_reset_zero: assert property (@(posedge i_core_clk)
		!i_rst_n |=> o_status_word == `CSW_STATUS_RESET)
		else $error("status word not cleared by reset");

	a_wrap_add: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADD && $signed(i_exec.opnd_a) >= 0
		&& $signed(i_exec.opnd_b) >= 0 && (i_exec.opnd_a + i_exec.opnd_b) >= 8'h80
		|=> o_status_word[2])
		else $error("signed wrap missing");

	a_parity_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rst_n |=> o_status_word[0] == ^$past(i_accumulator))
		else $error("parity wrong");

	a_carry_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rst_n && (!i_exec.valid || i_exec.op == CSW_OP_NONE) && !(i_psel && i_penable && i_pwrite)
		|=> $stable(o_status_word[7:6]))
		else $error("carry flags changed without cause");

	a_addc_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADDC
		|=> o_status_word[7] == (9'($past(i_exec.opnd_a)) + 9'($past(i_exec.opnd_b))
			+ 9'($past(o_status_word[7])) > 9'h0ff))
		else $error("add with carry wrong");

	a_sub_borrow_in: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_SUBTRACT_WITH_BORROW && o_status_word[7]
		|=> o_status_word[7] == ($past(i_exec.opnd_a) <= $past(i_exec.opnd_b)))
		else $error("subtract with borrow in wrong");

	a_half_sub: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_SUBTRACT_WITH_BORROW && !o_status_word[7]
		|=> o_status_word[6] == ($past(i_exec.opnd_a[3:0]) < $past(i_exec.opnd_b[3:0])))
		else $error("half borrow wrong");

	a_half_addc: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADDC
		|=> o_status_word[6] == (5'($past(i_exec.opnd_a[3:0])) + 5'($past(i_exec.opnd_b[3:0]))
			+ 5'($past(o_status_word[7])) > 5'h0f))
		else $error("half carry with carry in wrong");

	a_wrap_neg: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADD && i_exec.opnd_a[7] && i_exec.opnd_b[7]
		&& 8'(i_exec.opnd_a + i_exec.opnd_b) < 8'h80
		|=> o_status_word[2])
		else $error("negative wrap missing");

	a_wrap_mixed: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_ADD && i_exec.opnd_a[7] != i_exec.opnd_b[7]
		|=> !o_status_word[2])
		else $error("wrap set on mixed signs");

	a_bank_base: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rst_n |-> o_bank_base == 5'({o_status_word[4:3], 3'b000}))
		else $error("bank base does not follow bank select");

	a_half_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rst_n && i_exec.valid && !(i_psel && i_penable && i_pwrite) && i_exec.op inside {CSW_OP_MUL,
			CSW_OP_DIV, CSW_OP_DA, CSW_OP_COMPARE_JUMP_NOT_EQUAL, CSW_OP_SETC, CSW_OP_CLRC, CSW_OP_CPLC, CSW_OP_MOVC}
		|=> $stable(o_status_word[6]))
		else $error("half carry changed by op that keeps it");

	a_da_keep: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_exec.valid && i_exec.op == CSW_OP_DA && o_status_word[7]
		|=> o_status_word[7])
		else $error("decimal adjust dropped carry");

	a_user_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_soft_write |=> o_status_word[5] == $past(i_pwdata[5]))
		else $error("user flag not written");

	a_read_parity: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rst_n && apb_acc && apb_hit && !i_pwrite
		|=> o_prdata[0] == ^$past(i_accumulator))
		else $error("read parity wrong");

	a_reset_bank: assert property (@(posedge i_core_clk)
		!i_rst_n |=> o_bank_base == 5'h00 && !o_pready)
		else $error("bank base or ready not cleared by reset");
endmodule

`default_nettype wire

// file: verif/csw_tb.sv
/*
 Self-checking bench for the status word block: APB access plus random
 and corner-case execution ops. Assumes rtl package and header compiled first.
*/
`include "csw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	import csw_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e, bi, wi;
	logic [11:0] paddr = 0;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr;
	logic [7:0] acc = 0, sw, w = 0, a, b;
	logic [4:0] base;
	csw_exec_t ex = '0;
	int err_count = 0, num_checks = 0, cyc = 0;
	csw_status_word dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_exec(ex), .i_accumulator(acc),
		.o_status_word(sw), .o_bank_base(base));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask
	// master holds the request until pready is sampled high
	task automatic apb(logic wr, logic [11:0] ad, logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= ad;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	function automatic logic [7:0] nx(logic [7:0] v, csw_op_t op, logic [7:0] x, y);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] l;
		logic c;
		c = (op == CSW_OP_ADD) ? 1'b0 : v[7];
		case (op)
			CSW_OP_ADD, CSW_OP_ADDC, CSW_OP_SUBTRACT_WITH_BORROW: begin
				s = (op == CSW_OP_SUBTRACT_WITH_BORROW) ? x - y - c : x + y + c;
				h = (op == CSW_OP_SUBTRACT_WITH_BORROW) ? x[3:0] - y[3:0] - c : x[3:0] + y[3:0] + c;
				l = (op == CSW_OP_SUBTRACT_WITH_BORROW) ? x[6:0] - y[6:0] - c : x[6:0] + y[6:0] + c;
				v[7] = s[8];
				v[6] = h[4];
				v[2] = l[7] ^ s[8];
			end
			CSW_OP_MUL, CSW_OP_DIV: begin
				v[7] = 1'b0;
				v[2] = wi;
			end
			CSW_OP_DA: begin
				s = {1'b0, x};
				if (x[3:0] > 4'h9 || v[6]) s = s + 9'h006;
				if (s[7:4] > 4'h9 || c || s[8]) s = s + 9'h060;
				v[7] = c | s[8];
			end
			CSW_OP_COMPARE_JUMP_NOT_EQUAL: v[7] = x < y;
			CSW_OP_SETC: v[7] = 1'b1;
			CSW_OP_CLRC: v[7] = 1'b0;
			CSW_OP_CPLC: v[7] = ~c;
			CSW_OP_MOVC: v[7] = bi;
			default: ;
		endcase
		return v;
	endfunction
	task automatic op(csw_op_t o, logic [7:0] x, logic [7:0] y);
		logic [7:0] ac;
		ac = $urandom;
		bi = $urandom;
		wi = $urandom;
		@(posedge clk);
		ex <= '{1'b1, o, x, y, bi, wi};
		acc <= ac;
		@(posedge clk);
		ex.valid <= 1'b0;
		w = nx(w, o, x, y);
		#1;
		chk("flags", {w[7:1], ^ac}, sw);
		chk("bank_base", {w[4:3], 3'h0}, base);
	endtask
	initial begin
		void'($urandom(48055));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("reset word", 8'h00, sw);
		apb(1'b0, `CSW_STATUS_WORD_OFFSET, 8'h00);
		chk("reset read", 32'h0, rd);
		for (int i = 0; i < 8; i++) begin
			a = {3'($urandom), i[1:0], 3'h7};
			apb(1'b1, `CSW_STATUS_WORD_OFFSET, a);
			w = {a[7:1], 1'b0};
			apb(1'b0, `CSW_STATUS_WORD_OFFSET, 8'h00);
			chk("read word", {24'h0, a[7:1], ^acc}, rd);
			chk("good addr err", 32'h0, e);
			chk("bank_base", {a[4:3], 3'h0}, base);
		end
		apb(1'b1, 12'h0d4, 8'h55);
		chk("bad addr err", 1, e);
		chk("bad addr held", {w[7:1], ^acc}, sw);
		apb(1'b0, 12'h0d4, 8'h00);
		chk("bad read data", 32'h0, rd);
		chk("bad read err", 32'h1, e);
		pstrb <= 4'h0;
		apb(1'b1, `CSW_STATUS_WORD_OFFSET, ~w);
		pstrb <= 4'h1;
		chk("strobe off held", {w[7:1], ^acc}, sw);
		op(CSW_OP_ADD, 8'hff, 8'h01);
		op(CSW_OP_ADD, 8'h7f, 8'h01);
		op(CSW_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h01);
		op(CSW_OP_COMPARE_JUMP_NOT_EQUAL, 8'h05, 8'h05);
		op(CSW_OP_CLRC, 8'h00, 8'h00);
		op(CSW_OP_DA, 8'h9a, 8'h00);
		op(CSW_OP_MUL, 8'hff, 8'hff);
		for (int i = 0; i < 300; i++) begin
			a = $urandom;
			b = $urandom;
			op(csw_op_t'(4'($urandom)), a, b);
		end
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("second reset", 8'h00, sw);
		chk("second reset base", 32'h0, base);
		w = 8'h00;
		op(CSW_OP_ADD, 8'h0f, 8'h01);
		close_out();
	end
endmodule
`default_nettype wire
